// >>> hdl/acs_regs.vh
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_CLK_NS          50
`define ACS_PWRUP_NS        1000
`define ACS_CONV_HS_NS      4000
`define ACS_CONV_PD_NS      5000
`define ACS_PWRUP_CYC       ((`ACS_PWRUP_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_CONV_HS_CYC     ((`ACS_CONV_HS_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_CONV_PD_CYC     (`ACS_CONV_PD_NS / `ACS_CLK_NS)
`define ACS_RESULT_BITS     8
`define ACS_ST_DOWN         3'h0
`define ACS_ST_PWRUP        3'h1
`define ACS_ST_IDLE         3'h2
`define ACS_ST_CONV         3'h3
`define ACS_ST_PWRUP_PEND   3'h4
`define ACS_RESULT_RST      8'h00
`endif

// >>> hdl/acs_ctrl.v
// Summary of operation
// - after reset the converter is powered down and waits for a trigger rising edge.
// - trigger falling edge ends tracking, holds input and starts conversion.
// - high-speed conversion ends after 4 us; result latched, trigger level sampled.
// - trigger high at conversion end keeps the converter powered.
// - trigger low at conversion end latches result then powers down.
// - while powered down, trigger rising edge starts a 1 us power-up.
// - early trigger fall waits out power-up, then converts; never converts unpowered.
// - power-down mode conversion takes 5 us from the falling edge, or from power-up end after an early fall, then powers down if trigger is low at end.
// - trigger rising edge enables the serial port; reading may start after it.
// - a read before conversion end delivers the previous result.
// - a result arriving mid-read is loaded only after that read finishes.
// - a read after conversion end shifts out the current result.
// - serial port works while converter is powered down.
// - each trigger rising edge clears the serial clock counter.
// - after eight bits further clocks are ignored; re-armed at eighth falling edge.
// - data driven on first rising serial clock after trigger rise and each after.
// - data output goes high impedance on falling edge of the eighth clock.
// - serial port works with free-running or burst serial clock.
// - no data shifted before a trigger rising edge is seen.
`timescale 1ns/10ps
`default_nettype none
`include "acs_regs.vh"
module acs_ctrl #(
    parameter integer WIDTH       = `ACS_RESULT_BITS,
    parameter integer PWRUP_CYC   = `ACS_PWRUP_CYC,
    parameter integer CONV_HS_CYC = `ACS_CONV_HS_CYC,
    parameter integer CONV_PD_CYC = `ACS_CONV_PD_CYC
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             convert_trigger_n,
    input  wire             sclk,
    input  wire [WIDTH-1:0] sar_code,
    output reg              powered,
    output reg              hold,
    output reg              converting,
    output reg              dout_o,
    output reg              dout_oe
);
    localparam [31:0] PWRUP_W    = PWRUP_CYC;
    localparam [31:0] CONV_HS_W  = CONV_HS_CYC;
    localparam [31:0] CONV_PD_W  = CONV_PD_CYC;
    // the timer is eight bits wide; loads are cut to it on purpose, so counts above 255 cannot be used
    localparam [7:0]  PWRUP_LD   = PWRUP_W[7:0];
    localparam [7:0]  CONV_HS_LD = CONV_HS_W[7:0];
    localparam [7:0]  CONV_PD_LD = CONV_PD_W[7:0];

    // pins come from outside the clock domain: two flops, then a third for edges
    reg       trg_s1_q;
    reg       trg_s2_q;
    reg       trg_s3_q;
    reg       sck_s1_q;
    reg       sck_s2_q;
    reg       sck_s3_q;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            trg_s1_q <= 1'b0;
            trg_s2_q <= 1'b0;
            trg_s3_q <= 1'b0;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
        end else begin
            trg_s1_q <= convert_trigger_n;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
            sck_s1_q <= sclk;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end
    wire trg_rise = trg_s2_q & ~trg_s3_q;
    wire trg_fall = ~trg_s2_q & trg_s3_q;
    wire sck_rise = sck_s2_q & ~sck_s3_q;
    wire sck_fall = ~sck_s2_q & sck_s3_q;

    // converter sequencer
    reg  [2:0]       state_q;
    reg  [2:0]       state_d;
    reg  [7:0]       tmr_q;
    reg  [7:0]       tmr_d;
    reg              mode_pd_q;
    reg              mode_pd_d;
    wire             tmr_last;
    wire             conv_done;
    wire             reading;

    assign tmr_last  = (tmr_q == 8'h01);
    assign conv_done = (state_q == `ACS_ST_CONV) && tmr_last;

    always @* begin
        state_d   = state_q;
        tmr_d     = tmr_q;
        mode_pd_d = mode_pd_q;
        case (state_q)
            `ACS_ST_DOWN: begin
                // a wake-up is always followed by a conversion on the long budget
                mode_pd_d = 1'b1;
                if (trg_rise) begin
                    state_d = `ACS_ST_PWRUP;
                    tmr_d   = PWRUP_LD;
                end
            end
            `ACS_ST_PWRUP: begin
                tmr_d = tmr_q - 8'h01;
                if (trg_fall && tmr_last) begin
                    // power is good in this very cycle, so the pending wait would underflow
                    state_d   = `ACS_ST_CONV;
                    mode_pd_d = 1'b1;
                    tmr_d     = CONV_PD_LD;
                end else if (trg_fall) begin
                    state_d = `ACS_ST_PWRUP_PEND;
                end else if (tmr_last) begin
                    state_d = `ACS_ST_IDLE;
                end
            end
            `ACS_ST_PWRUP_PEND: begin
                // input already held at the falling edge; conversion waits for power
                tmr_d = tmr_q - 8'h01;
                if (tmr_last) begin
                    state_d   = `ACS_ST_CONV;
                    mode_pd_d = 1'b1;
                    tmr_d     = CONV_PD_LD;
                end
            end
            `ACS_ST_IDLE: begin
                if (trg_fall) begin
                    state_d = `ACS_ST_CONV;
                    tmr_d   = mode_pd_q ? CONV_PD_LD : CONV_HS_LD;
                end
            end
            `ACS_ST_CONV: begin
                tmr_d = tmr_q - 8'h01;
                if (tmr_last) begin
                    // the trigger level is seen through the synchroniser, two cycles late
                    if (trg_s2_q) begin
                        state_d   = `ACS_ST_IDLE;
                        mode_pd_d = 1'b0;
                    end else begin
                        state_d   = `ACS_ST_DOWN;
                        mode_pd_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d   = `ACS_ST_DOWN;
                tmr_d     = 8'h00;
                mode_pd_d = 1'b1;
            end
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= `ACS_ST_DOWN;
        end else begin
            state_q <= state_d;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tmr_q <= 8'h00;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // reset into power-down mode, so the first conversion after wake-up gets the long budget
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_pd_q <= 1'b1;
        end else begin
            mode_pd_q <= mode_pd_d;
        end
    end

    // status levels decode the state register; powered is low only in power-down
    always @* begin
        powered    = (state_q != `ACS_ST_DOWN);
        converting = (state_q == `ACS_ST_CONV);
        hold       = (state_q == `ACS_ST_CONV) || (state_q == `ACS_ST_PWRUP_PEND);
    end

    // result latch; a finished code waits while a read is running
    reg  [WIDTH-1:0] result_q;
    reg  [WIDTH-1:0] result_d;
    reg              pend_q;
    reg              pend_d;
    reg  [WIDTH-1:0] sar_code_q;
    reg  [WIDTH-1:0] sar_code_d;

    // the code is captured at conversion end so a deferred load is the right one
    always @* begin
        sar_code_d = sar_code_q;
        if (conv_done) begin
            sar_code_d = sar_code;
        end
    end

    always @* begin
        result_d = result_q;
        pend_d   = pend_q;
        if (conv_done) begin
            if (reading) begin
                pend_d = 1'b1;
            end else begin
                result_d = sar_code;
                pend_d   = 1'b0;
            end
        end else if (pend_q && !reading) begin
            result_d = sar_code_q;
            pend_d   = 1'b0;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sar_code_q <= `ACS_RESULT_RST;
        end else begin
            sar_code_q <= sar_code_d;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q <= `ACS_RESULT_RST;
        end else begin
            result_q <= result_d;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // serial port; independent of the converter power state
    localparam [31:0] WIDTH_W  = WIDTH;
    // the bit counter is four bits; the full count is cut to it on purpose
    localparam [3:0]  CNT_FULL = WIDTH_W[3:0];
    reg  [3:0]       cnt_q;
    reg  [3:0]       cnt_d;
    reg              armed_q;
    reg  [WIDTH-1:0] shreg_q;
    wire [WIDTH-1:0] shreg_d;
    wire             sh_step;
    wire             sh_first;
    wire             sh_last;
    reg              dout_d;
    reg              dout_oe_d;

    assign reading  = armed_q && (cnt_q != 4'h0);
    // a trigger rise wins over a clock edge in the same cycle; the host keeps them apart
    assign sh_step  = armed_q && !trg_rise && sck_rise && (cnt_q < CNT_FULL);
    assign sh_first = sh_step && (cnt_q == 4'h0);
    assign sh_last  = armed_q && !trg_rise && sck_fall && (cnt_q == CNT_FULL);

    always @* begin
        cnt_d = cnt_q;
        if (trg_rise) begin
            cnt_d = 4'h0;
        end else if (sh_step) begin
            cnt_d = cnt_q + 4'h1;
        end else if (sh_last) begin
            cnt_d = 4'h0;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // armed only by a trigger rise, so nothing leaves the pin before the first select
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_q <= 1'b0;
        end else if (trg_rise) begin
            armed_q <= 1'b1;
        end
    end

    // each stage above bit 0 takes the stored result bit below it on the first clock and the stage below after that; bit 0 takes zero
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_shift
            if (gi == 0) begin : g_lsb
                assign shreg_d[gi] = sh_step ? 1'b0 : shreg_q[gi];
            end else begin : g_upper
                assign shreg_d[gi] = sh_first ? result_q[gi-1] :
                                     sh_step  ? shreg_q[gi-1] : shreg_q[gi];
            end
        end
    endgenerate

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            shreg_q <= `ACS_RESULT_RST;
        end else begin
            shreg_q <= shreg_d;
        end
    end

    always @* begin
        dout_d    = dout_o;
        dout_oe_d = dout_oe;
        if (trg_rise) begin
            dout_oe_d = 1'b0;
        end else if (sh_first) begin
            // first edge takes the stored result, which is still the old one mid-conversion
            dout_d    = result_q[WIDTH-1];
            dout_oe_d = 1'b1;
        end else if (sh_step) begin
            dout_d    = shreg_q[WIDTH-1];
            dout_oe_d = 1'b1;
        end else if (sh_last) begin
            dout_oe_d = 1'b0;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dout_o <= 1'b0;
        end else begin
            dout_o <= dout_d;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= dout_oe_d;
        end
    end
endmodule
`default_nettype wire

// >>> tb/acs_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module acs_ctrl_monitor (
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             convert_trigger_n,
    input wire logic             sclk,
    input wire logic             powered,
    input wire logic             hold,
    input wire logic             converting,
    input wire logic             dout_o,
    input wire logic             dout_oe
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    logic [7:0] cnt_q;
    // ranges allow one cycle of synchroniser slack
    always @(posedge clk or posedge reset) begin
        if (reset) cnt_q <= 8'h00;
        else cnt_q <= converting ? cnt_q + 8'h01 : 8'h00;
    end
    // cycles spent powered; power-up takes 20 clocks before any conversion may run
    logic [7:0] pwr_q;
    always @(posedge clk or posedge reset) begin
        if (reset) pwr_q <= 8'h00;
        else if (!powered) pwr_q <= 8'h00;
        else if (pwr_q != 8'hFF) pwr_q <= pwr_q + 8'h01;
    end
    property p_conv_powered; converting |-> powered && hold && pwr_q >= 8'h14; endproperty
    a_conv_powered: assert property (p_conv_powered) else $error("conversion unpowered");
    property p_fall_starts; $fell(convert_trigger_n) && powered && !converting |-> ##[1:30] converting; endproperty
    a_fall_starts: assert property (p_fall_starts) else $error("no conversion after fall");
    property p_conv_len;
        $fell(converting) |-> (cnt_q >= 8'h4F && cnt_q <= 8'h51) || (cnt_q >= 8'h63 && cnt_q <= 8'h65);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("bad conversion length");
    property p_wake; $rose(convert_trigger_n) && !powered |-> ##[1:6] powered; endproperty
    a_wake: assert property (p_wake) else $error("no power-up");
    property p_stay; $fell(converting) && convert_trigger_n |-> powered; endproperty
    a_stay: assert property (p_stay) else $error("powered down in fast mode");
    property p_down; $fell(converting) && !convert_trigger_n |-> ##[0:2] !powered; endproperty
    a_down: assert property (p_down) else $error("no auto power-down");
    property p_oe_fall; $fell(dout_oe) |-> !$past(sclk) && !$past(sclk, 2); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("output released off falling edge");
    property p_oe_hold; $rose(dout_oe) |-> dout_oe[*8]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("output enable too short");
endmodule
bind acs_ctrl acs_ctrl_monitor u_mon (.clk(clk), .reset(reset),
    .convert_trigger_n(convert_trigger_n), .sclk(sclk), .powered(powered),
    .hold(hold), .converting(converting), .dout_o(dout_o), .dout_oe(dout_oe));
`default_nettype wire

// >>> tb/acs_host.sv
`timescale 1ns/10ps
`default_nettype none
module acs_host (
    input wire logic  clk,
    input wire logic  dout_o,
    input wire logic  dout_oe,
    output var logic  trig_n,
    output var logic  sclk
);
    logic last_q = 1'b0;
    // released line must not repeat the last bit
    wire logic line = dout_oe ? dout_o : ~last_q;
    initial trig_n = 1'b0;
    initial sclk = 1'b0;
    always @(posedge clk) if (dout_oe) last_q <= dout_o;
    // callers never start a read that spans a trigger rise
    task trig(input logic v);
        @(posedge clk) trig_n <= v;
    endtask
    // clock idles low, 400 ns period (four clocks high, four low); data taken after the falling edge
    task read_byte(output logic [7:0] b, output logic seen);
        integer i;
        seen = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk) sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (2) @(posedge clk);
            b = {b[6:0], line};
            seen = seen | dout_oe;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> tb/acs_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module acs_ctrl_bench;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] sar_code = 8'h00;
    logic [7:0] b;
    logic       seen;
    integer     checks = 0;
    integer     n_fail = 0;
    wire logic  trig_n, sclk, powered, hold, converting, dout_o, dout_oe;
    acs_ctrl DUT (.clk(clk), .reset(reset), .convert_trigger_n(trig_n), .sclk(sclk), .sar_code(sar_code),
        .powered(powered), .hold(hold), .converting(converting), .dout_o(dout_o), .dout_oe(dout_oe));
    acs_host host (.clk(clk), .dout_o(dout_o), .dout_oe(dout_oe), .trig_n(trig_n), .sclk(sclk));
    initial begin
        forever #25 clk = ~clk;
    end
    task step(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task t_idle;
        step(2);
        chk(powered, 1'b0);
        host.read_byte(b, seen);
        chk(seen, 1'b0);
        $display("t_idle done");
    endtask
    // fall inside the power-up window, trigger kept low to the end
    task t_pd;
        @(posedge clk) sar_code <= 8'hA5;
        host.trig(1'b1);
        step(8);
        chk(powered, 1'b1);
        host.trig(1'b0);
        step(30);
        chk({hold, converting}, 2'b11);
        step(110);
        chk(powered, 1'b0);
        host.read_byte(b, seen);
        chk(b, 8'hA5);
        chk(powered, 1'b0);
        $display("t_pd done");
    endtask
    task t_hs;
        host.trig(1'b1);
        step(30);
        @(posedge clk) sar_code <= 8'h3C;
        host.trig(1'b0);
        step(10);
        chk(converting, 1'b1);
        host.trig(1'b1);
        step(100);
        chk({powered, converting}, 2'b10);
        host.read_byte(b, seen);
        chk(b, 8'h3C);
        $display("t_hs done");
    endtask
    // read straddles the end of conversion, then a second read
    task t_defer;
        @(posedge clk) sar_code <= 8'hC3;
        host.trig(1'b0);
        step(10);
        host.trig(1'b1);
        step(40);
        host.read_byte(b, seen);
        chk(b, 8'h3C);
        host.read_byte(b, seen);
        chk(b, 8'hC3);
        chk(powered, 1'b1);
        $display("t_defer done");
    endtask
    initial begin
        step(10);
        reset <= 1'b0;
        t_idle;
        t_pd;
        t_hs;
        t_defer;
        end_of_test;
    end
    initial begin
        step(3000);
        n_fail = n_fail + 1;
        end_of_test;
    end
endmodule
`default_nettype wire
